// ===== scm_batt_mon.sv
// Battery comparator gating: active only with monitoring on and main supply up
// Assumes comparator levels synchronous to sys_clk
`timescale 1ns/1ns
`default_nettype none
module scm_batt_mon (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic reset,
   // Gating
   input  wire logic check_enable,
   input  wire logic main_supply_present,
   // Comparators
   input  wire logic below_error,
   input  wire logic below_warning,
   // Results
   output var  logic batt_low,
   output var  logic batt_warn
);
   logic active;

   assign active = check_enable && main_supply_present;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         batt_low  <= 1'b0;
         batt_warn <= 1'b0;
      end else begin
         batt_low  <= active && below_error;
         batt_warn <= active && below_warning;
      end
   end
endmodule
`default_nettype wire

// ===== scm_defines.svh
// Register offsets, field positions, reset values and command codes
// Assumes inclusion by bare name from the top level and testbench source files
`ifndef SCM_DEFINES_SVH
`define SCM_DEFINES_SVH

// Register offsets
`define SCM_ADDR_SENSING     8'h03
`define SCM_ADDR_BATT_THR    8'h05
`define SCM_ADDR_STATUS      8'h10
`define SCM_ADDR_COMMAND     8'h11

// Command codes
`define SCM_CMD_SOFT_RESTART 8'h02
`define SCM_CMD_RELOAD       8'h03
`define SCM_CMD_SLEEP        8'h04
`define SCM_CMD_CLEAR_FLAGS  8'h05

// Status bit positions
`define SCM_ST_STARTUP       0
`define SCM_ST_CFG_CRC       1
`define SCM_ST_CTR_CRC       2
`define SCM_ST_POSITION      3
`define SCM_ST_BATT_LOW      4
`define SCM_ST_BATT_WARN     5
`define SCM_ST_PWR_DOWN      6
`define SCM_ST_BOOT          7

// Field positions
`define SCM_BATT_CHECK_BIT   6
`define SCM_ACCEL_MSB        5
`define SCM_ACCEL_LSB        3
`define SCM_BIAS_MSB         2
`define SCM_BIAS_LSB         0
`define SCM_THR_MSB          3
`define SCM_THR_LSB          2

// Reset values and calibration mode code
`define SCM_SENSING_RESET    8'h46
`define SCM_BATT_THR_RESET   8'h00
`define SCM_STATUS_RESET     8'h00
`define SCM_CAL_MODE_CODE    2'h1

`endif

// ===== scm_host_model.sv
// Host model: byte reads and writes towards the slave front end
// Assumes strobes and address sampled on the rising edge of sys_clk
`timescale 1ns/1ns
`default_nettype none
module scm_host_model (
   // Clock
   input  wire logic       sys_clk,
   // Register port
   input  wire logic [7:0] reg_rdata,
   output var  logic       reg_wr,
   output var  logic       reg_rd,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // One byte write, held up to the taking edge
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      // Released lines show no stale value
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   // One byte read, data taken once registered
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(posedge sys_clk);
      #1;
      d = reg_rdata;
   endtask

   // Bias kept at nominal trim with monitoring on
   task automatic trim_bias();
      write_reg(8'h03, 8'h46);
   endtask

   // Acknowledge all status flags
   task automatic clear_flags();
      write_reg(8'h11, 8'h05);
   endtask
endmodule
`default_nettype wire

// ===== scm_pkg.sv
// Types shared by the status and command monitor
// Assumes nothing of its surroundings
package scm_pkg;
   typedef logic [7:0] scm_byte_t;
   typedef enum logic {SCM_RUN, SCM_ASLEEP} scm_sleep_e;
endpackage

// ===== scm_sleep_ctrl.sv
// Sleep mode tracker: entry by command, exit by any register write other than a sleep command
// Assumes write strobes from the slave front end, one per written byte
`timescale 1ns/1ns
`default_nettype none
module scm_sleep_ctrl
   import scm_pkg::*;
(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic reset,
   // Requests
   input  wire logic sleep_cmd,
   input  wire logic any_write,
   // State
   output var  logic asleep,
   output var  logic sleep_entry,
   output var  logic wake
);
   scm_sleep_e state_reg;
   scm_sleep_e state_next;
   logic       go_sleep;
   logic       go_wake;

   assign go_sleep = (state_reg == SCM_RUN) && sleep_cmd;
   assign go_wake  = (state_reg == SCM_ASLEEP) && any_write && !sleep_cmd;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SCM_RUN:    if (go_sleep) state_next = SCM_ASLEEP;
         SCM_ASLEEP: if (go_wake) state_next = SCM_RUN;
         default:    state_next = SCM_RUN;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_reg   <= SCM_RUN;
         sleep_entry <= 1'b0;
         wake        <= 1'b0;
      end else begin
         state_reg   <= state_next;
         sleep_entry <= go_sleep;
         wake        <= go_wake;
      end
   end

   assign asleep = (state_reg == SCM_ASLEEP);
endmodule
`default_nettype wire

// ===== scm_top.sv
// Status byte, command register, sleep control and battery monitor outputs
// Assumes a slave front end that hands over decoded byte reads and writes
//
// How it works
// - status bits 0..7: startup, cfg CRC, counter CRC, position, batt low, warn, power down, boot
// - command 0x02 pulses a soft restart, leaving counter and configuration alone
// - command 0x03 requests reload from EEPROM and sets status bit 7, as a preset pulse does
// - command 0x04 halts sensing; register interface stays alive
// - any register write while asleep, other than command 0x04, wakes and restarts tracking
// - reads while asleep leave the device asleep
// - sleep entry sets status bit 7 and asserts the fault output
// - waking releases the fault output unless any of status bits 0..4 is set; bit 7 stays until cleared
// - command 0x05 clears the whole status byte
// - battery checking needs enable bit 6 and main supply present
// - battery below error sets the flag, fault output and frame error bit
// - battery below warning drives warning output and optional frame warning bit
// - bits 3:2 of byte 0x05 select the threshold pair, 00 highest
// - bits 5:3 of byte 0x03 set the acceleration limit, 000 highest
// - bits 2:0 of byte 0x03 trim oscillator bias, 110 nominal
// - error output mode 01 selects calibration and drives clock to the pin
// - fault output low while any of status bits 0..4 is set
// - a cleared flag sets again at once while its cause persists
// - the battery warning reaches the warning output and frame warning bit, never the fault output
`timescale 1ns/1ns
`default_nettype none
`include "scm_defines.svh"
module scm_top
   import scm_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // Register access from the slave front end
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output var  logic [7:0] reg_rdata,
   // Fault causes
   input  wire logic       startup_fault_in,
   input  wire logic       cfg_crc_fault_in,
   input  wire logic       counter_crc_fault_in,
   input  wire logic       position_fault_in,
   input  wire logic       power_down_reset_in,
   input  wire logic       preset_pulse_in,
   // Supply and battery comparators
   input  wire logic       main_supply_present,
   input  wire logic       batt_below_error,
   input  wire logic       batt_below_warning,
   // Loose configuration
   input  wire logic       frame_warning_enable,
   input  wire logic [1:0] err_out_mode,
   // Indicators
   output var  logic       fault_out_n,
   output var  logic       warning_out_n,
   output var  logic       frame_error_bit,
   output var  logic       frame_warning_bit,
   // Core control
   output var  logic       sensing_enable,
   output var  logic       soft_restart,
   output var  logic       reload_request,
   output var  logic [2:0] accel_limit,
   output var  logic [2:0] osc_bias_trim,
   output var  logic [1:0] battery_threshold_sel,
   // Calibration
   output var  logic       cal_mode,
   output var  logic       cal_clock_pin
);
   // Registers
   scm_byte_t sensing_power_config_reg;
   scm_byte_t sensing_power_config_next;
   scm_byte_t battery_threshold_config_reg;
   scm_byte_t battery_threshold_config_next;
   scm_byte_t fault_flags_reg;
   scm_byte_t fault_flags_next;
   scm_byte_t rdata_next;
   logic      cal_toggle_reg;

   // Decode
   logic      wr_sensing;
   logic      wr_thr;
   logic      wr_status;
   logic      wr_cmd;
   logic      cmd_restart;
   logic      cmd_reload;
   logic      cmd_sleep;
   logic      cmd_clear;
   scm_byte_t status_set;
   logic      any_fault;
   logic      asleep;
   logic      sleep_entry;
   logic      wake;
   logic      batt_low;
   logic      batt_warn;
   logic      boot_event;

   assign wr_sensing  = reg_wr && (reg_addr == `SCM_ADDR_SENSING);
   assign wr_thr      = reg_wr && (reg_addr == `SCM_ADDR_BATT_THR);
   assign wr_status   = reg_wr && (reg_addr == `SCM_ADDR_STATUS);
   assign wr_cmd      = reg_wr && (reg_addr == `SCM_ADDR_COMMAND);
   // Unlisted codes match nothing below
   assign cmd_restart = wr_cmd && (reg_wdata == `SCM_CMD_SOFT_RESTART);
   assign cmd_reload  = wr_cmd && (reg_wdata == `SCM_CMD_RELOAD);
   assign cmd_sleep   = wr_cmd && (reg_wdata == `SCM_CMD_SLEEP);
   assign cmd_clear   = wr_cmd && (reg_wdata == `SCM_CMD_CLEAR_FLAGS);

   // Sleep tracking
   scm_sleep_ctrl u_sleep (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .sleep_cmd   (cmd_sleep),
      .any_write   (reg_wr),
      .asleep      (asleep),
      .sleep_entry (sleep_entry),
      .wake        (wake)
   );

   // Battery monitor
   scm_batt_mon u_batt (
      .sys_clk             (sys_clk),
      .reset               (reset),
      .check_enable        (sensing_power_config_reg[`SCM_BATT_CHECK_BIT]),
      .main_supply_present (main_supply_present),
      .below_error         (batt_below_error),
      .below_warning       (batt_below_warning),
      .batt_low            (batt_low),
      .batt_warn           (batt_warn)
   );

   // Status set sources
   assign boot_event = preset_pulse_in || cmd_reload || sleep_entry;
   assign status_set = {boot_event,
                        power_down_reset_in,
                        batt_warn,
                        batt_low,
                        position_fault_in,
                        counter_crc_fault_in,
                        cfg_crc_fault_in,
                        startup_fault_in};

   // Clear or overwrite first, live causes win over both
   assign fault_flags_next = (cmd_clear ? `SCM_STATUS_RESET :
                              wr_status ? reg_wdata : fault_flags_reg)
                             | status_set;

   assign sensing_power_config_next    = wr_sensing ? reg_wdata : sensing_power_config_reg;
   assign battery_threshold_config_next = wr_thr ? reg_wdata : battery_threshold_config_reg;

   // Fault output: flags 0..4 or sleeping; warning excluded
   assign any_fault = (|fault_flags_reg[`SCM_ST_BATT_LOW:`SCM_ST_STARTUP]) || asleep;

   // Read mux, command register reads as zero
   always_comb begin
      rdata_next = 8'h00;
      case (reg_addr)
         `SCM_ADDR_SENSING:  rdata_next = sensing_power_config_reg;
         `SCM_ADDR_BATT_THR: rdata_next = battery_threshold_config_reg;
         `SCM_ADDR_STATUS:   rdata_next = fault_flags_reg;
         default:            rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sensing_power_config_reg     <= `SCM_SENSING_RESET;
         battery_threshold_config_reg <= `SCM_BATT_THR_RESET;
         fault_flags_reg              <= `SCM_STATUS_RESET;
      end else begin
         sensing_power_config_reg     <= sensing_power_config_next;
         battery_threshold_config_reg <= battery_threshold_config_next;
         fault_flags_reg              <= fault_flags_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end
   end

   // Indicators
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         fault_out_n       <= 1'b1;
         warning_out_n     <= 1'b1;
         frame_error_bit   <= 1'b0;
         frame_warning_bit <= 1'b0;
      end else begin
         fault_out_n       <= !any_fault;
         warning_out_n     <= !batt_warn;
         frame_error_bit   <= |fault_flags_reg[`SCM_ST_BATT_LOW:`SCM_ST_STARTUP];
         frame_warning_bit <= batt_warn && frame_warning_enable;
      end
   end

   // Core control
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sensing_enable <= 1'b1;
         soft_restart   <= 1'b0;
         reload_request <= 1'b0;
      end else begin
         sensing_enable <= !asleep;
         soft_restart   <= cmd_restart;
         reload_request <= cmd_reload;
      end
   end

   // Configuration fields
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         accel_limit           <= 3'h0;
         osc_bias_trim         <= 3'h6;
         battery_threshold_sel <= 2'h0;
      end else begin
         accel_limit           <= sensing_power_config_reg[`SCM_ACCEL_MSB:`SCM_ACCEL_LSB];
         osc_bias_trim         <= sensing_power_config_reg[`SCM_BIAS_MSB:`SCM_BIAS_LSB];
         battery_threshold_sel <= battery_threshold_config_reg[`SCM_THR_MSB:`SCM_THR_LSB];
      end
   end

   // Calibration clock out, half the internal clock rate
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cal_mode       <= 1'b0;
         cal_toggle_reg <= 1'b0;
         cal_clock_pin  <= 1'b0;
      end else begin
         cal_mode       <= (err_out_mode == `SCM_CAL_MODE_CODE);
         cal_toggle_reg <= !cal_toggle_reg;
         cal_clock_pin  <= cal_mode && cal_toggle_reg;
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   chk_clear_cmd: assert property (
      cmd_clear |=> fault_flags_reg == $past(status_set))
      else $error("clear command left flags set");

   chk_restart_pulse: assert property (
      cmd_restart |=> soft_restart && !reload_request
         && sensing_power_config_reg == $past(sensing_power_config_reg))
      else $error("soft restart not issued or config changed");

   chk_reload_boot: assert property (
      cmd_reload |=> reload_request && fault_flags_reg[`SCM_ST_BOOT])
      else $error("reload request or boot flag missing");

   chk_sleep_entry: assert property (
      (cmd_sleep && !asleep) |=> ##1 (!sensing_enable && !fault_out_n
         && fault_flags_reg[`SCM_ST_BOOT]))
      else $error("sleep entry effects missing");

   chk_read_stays: assert property (
      (asleep && !reg_wr) |=> asleep)
      else $error("left sleep without a write");

   chk_write_wakes: assert property (
      (asleep && reg_wr && !cmd_sleep) |=> !asleep ##1 sensing_enable)
      else $error("write did not wake");

   chk_boot_held: assert property (
      (fault_flags_reg[`SCM_ST_BOOT] && !cmd_clear && !wr_status)
         |=> fault_flags_reg[`SCM_ST_BOOT])
      else $error("boot flag dropped without clear");

   chk_unknown_cmd: assert property (
      (wr_cmd && !cmd_restart && !cmd_reload && !cmd_sleep && !cmd_clear)
         |=> !soft_restart && !reload_request
            && fault_flags_reg == ($past(fault_flags_reg) | $past(status_set)))
      else $error("unknown command had an effect");

   chk_batt_gate: assert property (
      (!main_supply_present || !sensing_power_config_reg[`SCM_BATT_CHECK_BIT])
         |=> !batt_low && !batt_warn)
      else $error("battery check active while gated");

   chk_fault_pin: assert property (
      (|fault_flags_reg[`SCM_ST_BATT_LOW:`SCM_ST_STARTUP]) |=> !fault_out_n && frame_error_bit)
      else $error("fault flag not on fault output");

   chk_warn_only: assert property (
      (fault_flags_reg[`SCM_ST_BATT_LOW:`SCM_ST_STARTUP] == 5'h0 && !asleep) |=> fault_out_n)
      else $error("fault output asserted without fault");

   chk_set_wins: assert property (
      (status_set != 8'h00) |=> (fault_flags_reg & $past(status_set)) == $past(status_set))
      else $error("live cause lost against clear");

   chk_cal_mode: assert property (
      (err_out_mode == `SCM_CAL_MODE_CODE) |=> cal_mode)
      else $error("calibration mode not entered");

   chk_batt_low_bit: assert property (
      batt_low |=> fault_flags_reg[`SCM_ST_BATT_LOW])
      else $error("battery fault flag not set");

   chk_boot_sources: assert property (
      (preset_pulse_in || sleep_entry) |=> fault_flags_reg[`SCM_ST_BOOT])
      else $error("boot trigger flag not set");

   chk_power_down_flag: assert property (
      power_down_reset_in |=> fault_flags_reg[`SCM_ST_PWR_DOWN])
      else $error("power down flag not set");

   chk_warn_pins: assert property (
      batt_warn |=> !warning_out_n && (frame_warning_bit == $past(frame_warning_enable)))
      else $error("battery warning not shown");

   chk_fields_copy: assert property (
      1'b1 |=> accel_limit == $past(sensing_power_config_reg[`SCM_ACCEL_MSB:`SCM_ACCEL_LSB])
         && osc_bias_trim == $past(sensing_power_config_reg[`SCM_BIAS_MSB:`SCM_BIAS_LSB]))
      else $error("sensing fields not passed on");

   chk_thr_copy: assert property (
      1'b1 |=> battery_threshold_sel
         == $past(battery_threshold_config_reg[`SCM_THR_MSB:`SCM_THR_LSB]))
      else $error("threshold field not passed on");

   chk_asleep_halts: assert property (
      asleep |=> !sensing_enable)
      else $error("sensing active while asleep");

   chk_status_write: assert property (
      wr_status |=> fault_flags_reg == ($past(reg_wdata) | $past(status_set)))
      else $error("status overwrite not taken");

   chk_wake_release: assert property (
      (wake && fault_flags_reg[`SCM_ST_BATT_LOW:`SCM_ST_STARTUP] == 5'h0)
         |=> fault_out_n)
      else $error("fault output held after wake");

   chk_cal_off: assert property (
      !cal_mode |=> !cal_clock_pin)
      else $error("calibration clock without calibration mode");

   cov_sleep_wake: cover property (cmd_sleep ##[1:20] wake);
   cov_clear_flags: cover property (fault_flags_reg != 8'h00 ##1 cmd_clear);
   cov_reload: cover property (cmd_reload);
   cov_batt_warn: cover property (!warning_out_n && frame_warning_bit);
   cov_cal_clock: cover property (cal_mode && cal_clock_pin);
endmodule
`default_nettype wire

// ===== testbench.sv
// Testbench for the status and command monitor
// Assumes the host model drives the register port
`timescale 1ns/1ns
`default_nettype none
`include "scm_defines.svh"
module testbench;
   import scm_pkg::*;
   logic       sys_clk = 1'b0;
   logic       reset;
   logic       reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, smp;
   logic [5:0] cause;
   logic       main_sup, b_err, b_wrn, fw_en;
   logic [1:0] eo_mode;
   logic       fault_out_n, warning_out_n, frame_error_bit, frame_warning_bit;
   logic       sensing_enable, soft_restart, reload_request, cal_mode, cal_clock_pin;
   logic [2:0] accel_limit, osc_bias_trim;
   logic [1:0] battery_threshold_sel;
   logic [2:0] bitpos [6] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd6, 3'd7};
   logic [7:0] codes [4] = '{8'h00, 8'h01, 8'h06, 8'hFF};
   int         err_count = 0;
   int         compares = 0;
   int         rst_cnt = 0;
   int         rld_cnt = 0;

   always #10 sys_clk = ~sys_clk;

   scm_host_model host_u (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   scm_top dut_u (.sys_clk(sys_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .startup_fault_in(cause[0]), .cfg_crc_fault_in(cause[1]),
      .counter_crc_fault_in(cause[2]), .position_fault_in(cause[3]),
      .power_down_reset_in(cause[4]), .preset_pulse_in(cause[5]),
      .main_supply_present(main_sup), .batt_below_error(b_err),
      .batt_below_warning(b_wrn), .frame_warning_enable(fw_en), .err_out_mode(eo_mode),
      .fault_out_n(fault_out_n), .warning_out_n(warning_out_n),
      .frame_error_bit(frame_error_bit), .frame_warning_bit(frame_warning_bit),
      .sensing_enable(sensing_enable), .soft_restart(soft_restart),
      .reload_request(reload_request), .accel_limit(accel_limit),
      .osc_bias_trim(osc_bias_trim), .battery_threshold_sel(battery_threshold_sel),
      .cal_mode(cal_mode), .cal_clock_pin(cal_clock_pin));

   // Pulse counters
   always @(posedge sys_clk) begin
      if (soft_restart === 1'b1) rst_cnt++;
      if (reload_request === 1'b1) rld_cnt++;
   end

   task automatic test_done();
      $display("compares %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host_u.read_reg(a, v);
      chk(v, exp, "register read");
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      host_u.write_reg(a, v);
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      $display("wrong value at %0t: run hung", $time);
      test_done();
   end

   initial begin
      reset = 1'b1;
      cause = 6'h00;
      main_sup = 1'b1;
      b_err = 1'b0;
      b_wrn = 1'b0;
      fw_en = 1'b0;
      eo_mode = 2'b00;
      repeat (16) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      // Reset values
      chk(fault_out_n, 8'h01, "fault idle");
      chk(warning_out_n, 8'h01, "warn idle");
      chk(sensing_enable, 8'h01, "sensing on");
      chk(osc_bias_trim, 8'h06, "bias reset");
      chk(accel_limit, 8'h00, "accel reset");
      chk(battery_threshold_sel, 8'h00, "thr reset");
      rd(`SCM_ADDR_SENSING, 8'h46);
      rd(`SCM_ADDR_BATT_THR, 8'h00);
      rd(`SCM_ADDR_STATUS, 8'h00);
      rd(`SCM_ADDR_COMMAND, 8'h00);
      $display("test reset done");
      // Configuration fields
      wr(`SCM_ADDR_SENSING, 8'h2B);
      cyc(3);
      chk(accel_limit, 8'h05, "accel field");
      chk(osc_bias_trim, 8'h03, "bias field");
      for (int t = 0; t < 4; t++) begin
         wr(`SCM_ADDR_BATT_THR, {4'h0, t[1:0], 2'b00});
         cyc(3);
         chk(battery_threshold_sel, {6'h00, t[1:0]}, "thr field");
      end
      wr(8'h20, 8'h5A);
      rd(8'h20, 8'h00);
      wr(`SCM_ADDR_BATT_THR, 8'h00);
      host_u.trim_bias();
      cyc(3);
      chk(osc_bias_trim, 8'h06, "bias nominal");
      $display("test config done");
      // Status causes, overwrite and clear
      for (int i = 0; i < 6; i++) begin
         cause = 6'h01 << i;
         cyc(3);
         rd(`SCM_ADDR_STATUS, 8'h01 << bitpos[i]);
         chk(fault_out_n, (i < 4) ? 8'h00 : 8'h01, "fault level");
         wr(`SCM_ADDR_STATUS, 8'h00);
         rd(`SCM_ADDR_STATUS, 8'h01 << bitpos[i]);
         cause = 6'h00;
         host_u.clear_flags();
         cyc(2);
         rd(`SCM_ADDR_STATUS, 8'h00);
         chk(fault_out_n, 8'h01, "fault released");
      end
      $display("test status done");
      // Battery monitor
      b_err = 1'b1;
      cyc(4);
      chk(fault_out_n, 8'h00, "batt fault");
      chk(frame_error_bit, 8'h01, "frame error");
      rd(`SCM_ADDR_STATUS, 8'h10);
      b_err = 1'b0;
      cyc(4);
      host_u.clear_flags();
      fw_en = 1'b1;
      b_wrn = 1'b1;
      cyc(4);
      chk(warning_out_n, 8'h00, "batt warn");
      chk(frame_warning_bit, 8'h01, "frame warn");
      chk(fault_out_n, 8'h01, "warn not on fault");
      rd(`SCM_ADDR_STATUS, 8'h20);
      main_sup = 1'b0;
      cyc(4);
      chk(warning_out_n, 8'h01, "no supply");
      main_sup = 1'b1;
      wr(`SCM_ADDR_SENSING, 8'h06);
      b_err = 1'b1;
      cyc(4);
      chk(warning_out_n, 8'h01, "monitor off warn");
      chk(fault_out_n, 8'h01, "monitor off fault");
      b_err = 1'b0;
      b_wrn = 1'b0;
      fw_en = 1'b0;
      wr(`SCM_ADDR_SENSING, 8'h46);
      host_u.clear_flags();
      cyc(2);
      rd(`SCM_ADDR_STATUS, 8'h00);
      $display("test battery done");
      // Commands
      wr(`SCM_ADDR_COMMAND, `SCM_CMD_SOFT_RESTART);
      cyc(3);
      chk(8'(rst_cnt), 8'h01, "soft restart");
      chk(8'(rld_cnt), 8'h00, "no reload");
      rd(`SCM_ADDR_SENSING, 8'h46);
      wr(`SCM_ADDR_COMMAND, `SCM_CMD_RELOAD);
      cyc(3);
      chk(8'(rld_cnt), 8'h01, "reload");
      rd(`SCM_ADDR_STATUS, 8'h80);
      host_u.clear_flags();
      for (int c = 0; c < 4; c++) begin
         wr(`SCM_ADDR_COMMAND, codes[c]);
         cyc(3);
         chk(8'(rst_cnt + rld_cnt), 8'h02, "ignored code");
         chk(sensing_enable, 8'h01, "still sensing");
         rd(`SCM_ADDR_STATUS, 8'h00);
      end
      $display("test command done");
      // Sleep entry and exit
      wr(`SCM_ADDR_COMMAND, `SCM_CMD_SLEEP);
      cyc(3);
      chk(sensing_enable, 8'h00, "asleep");
      chk(fault_out_n, 8'h00, "sleep fault");
      rd(`SCM_ADDR_STATUS, 8'h80);
      rd(`SCM_ADDR_SENSING, 8'h46);
      chk(sensing_enable, 8'h00, "reads keep sleep");
      wr(8'h20, 8'h5A);
      cyc(3);
      chk(sensing_enable, 8'h01, "awake");
      chk(fault_out_n, 8'h01, "wake fault off");
      rd(`SCM_ADDR_STATUS, 8'h80);
      host_u.clear_flags();
      cyc(2);
      rd(`SCM_ADDR_STATUS, 8'h00);
      $display("test sleep done");
      // Calibration output
      eo_mode = 2'b01;
      cyc(3);
      chk(cal_mode, 8'h01, "cal mode");
      for (int k = 0; k < 8; k++) begin
         smp[k] = cal_clock_pin;
         cyc(1);
      end
      chk({1'b0, smp[7:1] ^ smp[6:0]}, 8'h7F, "cal clock toggles");
      for (int m = 0; m < 3; m++) begin
         eo_mode = (m == 0) ? 2'b00 : 2'(m + 1);
         cyc(3);
         chk({cal_mode, cal_clock_pin}, 8'h00, "cal off");
      end
      $display("test calibration done");
      test_done();
   end
endmodule
`default_nettype wire
